//--- logic/cfg_fwd_pkg.sv
// Constants shared by the configuration forwarding logic of the bridge.
package cfg_fwd_pkg;
  // Bus command codes as they appear on the command/byte-enable lines.
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // Configuration address type encodings in AD[1:0].
  localparam logic [1:0] TYPE0 = 2'h0;
  localparam logic [1:0] TYPE1 = 2'h1;
  // Field positions inside a Type 1 configuration address, and the select lines of a converted Type 0 address.
  localparam int BUS_HI = 23;
  localparam int BUS_LO = 16;
  localparam int DEV_HI = 15;
  localparam int DEV_LO = 11;
  localparam int FN_HI = 10;
  localparam int FN_LO = 8;
  localparam int REG_HI = 7;
  localparam int REG_LO = 2;
  localparam int IDSEL_LO = 16;
  localparam int IDSEL_COUNT = 16;
  // Qualifying values for special cycle generation and upstream forwarding, and the zero device field of a converted address.
  localparam logic [4:0] DEV_ALL = 5'h1F;
  localparam logic [2:0] FN_ALL = 3'h7;
  localparam logic [5:0] SPECIAL_REG = 6'h00;
  localparam logic [4:0] DEV_ZERO = 5'h00;
  // Reset values of the select lines and of the word, byte-enable and index outputs.
  localparam logic SELECT_IDLE_N = 1'h1;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [3:0] BE_NONE_N = 4'hF;
  localparam logic [5:0] INDEX_ZERO = 6'h00;

  // What an address phase asks the bridge to do.
  typedef enum logic [2:0]
  {
    KIND_NONE = 3'h0,
    KIND_OWN = 3'h1,
    KIND_CONV = 3'h2,
    KIND_DOWN = 3'h3,
    KIND_UP = 3'h4,
    KIND_SPEC = 3'h5
  } kind_t;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'b001,
    S_CLAIM = 3'b010,
    S_RESP = 3'b100
  } state_t;
endpackage

//--- logic/delayed_entry.sv
// One delayed transaction slot: request fields, far-bus outcome and completion data.
`timescale 1ns/1ps
module delayed_entry
(
  input wire logic core_clk, // Clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic load, // Capture a new request.
  input wire logic [31:0] loadAddr, // Original address of the request.
  input wire logic [3:0] loadCmd, // Original bus command.
  input wire logic loadSide, // Request came from the secondary bus.
  input wire logic finish, // Far-bus cycle ended.
  input wire logic finishAbort, // Far-bus cycle ended in a master abort.
  input wire logic [31:0] finishData, // Read data from the far bus.
  input wire logic clear, // Retire the slot.
  output logic busy, // Slot holds a request.
  output logic complete, // Far-bus cycle is over.
  output logic aborted, // Far-bus cycle was master aborted.
  output logic [31:0] addr, // Stored address.
  output logic [3:0] cmd, // Stored command.
  output logic side, // Stored originating side.
  output logic [31:0] data // Stored completion data.
);
  import cfg_fwd_pkg::*;

  wire finishNow = finish && busy && !complete;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      complete <= 1'b0;
      aborted <= 1'b0;
      addr <= WORD_ZERO;
      cmd <= CMD_SPECIAL;
      side <= 1'b0;
      data <= WORD_ZERO;
    end
    else if (clear)
    begin
      busy <= 1'b0;
      complete <= 1'b0;
      aborted <= 1'b0;
    end
    else if (load && !busy)
    begin
      busy <= 1'b1;
      complete <= 1'b0;
      aborted <= 1'b0;
      addr <= loadAddr;
      cmd <= loadCmd;
      side <= loadSide;
    end
    else if (finishNow)
    begin
      complete <= 1'b1;
      aborted <= finishAbort;
      data <= finishData;
    end
  end
endmodule

//--- logic/cfg_forward.sv
// Configuration transaction claim, translation and delayed forwarding for a two-port bridge.
`timescale 1ns/1ps
module cfg_forward
(
  input wire logic core_clk, // Clock, 10 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic addrPhase, // Address phase of a new transaction, one cycle.
  input wire logic fromSecondary, // Transaction was started on the secondary bus.
  input wire logic [31:0] ad, // Address in the address phase, data in a data phase.
  input wire logic [3:0] commandByteEnable_n, // Command, then active-low byte enables.
  input wire logic primaryConfigSelect, // Configuration select of the bridge itself.
  input wire logic dataPhase, // Initiator ready in the data phase, one cycle.
  input wire logic moreData, // Initiator wants further data phases.
  input wire logic [7:0] primaryBus, // Primary bus number.
  input wire logic [7:0] secondaryBus, // Secondary bus number.
  input wire logic [7:0] subordinateBus, // Subordinate bus number.
  input wire logic [31:0] cfgReadData, // Own configuration word at cfgIndex.
  input wire logic farDone, // Far-bus cycle of the pending request ended, pulse.
  input wire logic farMasterAbort, // That cycle ended in a master abort.
  input wire logic [31:0] farReadData, // Read data returned by the far bus.
  output cfg_fwd_pkg::kind_t claimKind, // Kind of the transaction being served.
  output logic primaryDeviceSelect_n, // Bridge claims on the primary bus.
  output logic secondaryDeviceSelect_n, // Bridge claims on the secondary bus.
  output logic targetReady, // Data moves in this response cycle.
  output logic targetStop, // Stop: retry alone, disconnect with targetReady.
  output logic [31:0] readData, // Data returned to the initiator.
  output logic [5:0] cfgIndex, // Register index of an own access.
  output logic cfgWrite, // Write own configuration word, pulse.
  output logic [31:0] cfgWriteData, // Data of that write.
  output logic [3:0] cfgByteEnable_n, // Byte enables of that write.
  output logic fwdValid, // Issue a cycle on the far bus, pulse.
  output logic fwdToSecondary, // Far bus is the secondary bus.
  output logic [31:0] fwdAddr, // Address of the far cycle.
  output logic [3:0] fwdCommand, // Command of the far cycle.
  output logic [31:0] fwdData, // Write data or special cycle message.
  output logic [3:0] fwdByteEnable_n // Byte enables of the far cycle.
);
  import cfg_fwd_pkg::*;

  state_t state;
  kind_t heldKind;
  logic [31:0] heldAd;
  logic [3:0] heldCmd;
  logic heldSide;
  logic heldMatch;
  logic entryBusy;
  logic entryComplete;
  logic entryAborted;
  logic [31:0] entryAddr;
  logic [3:0] entryCmd;
  logic entrySide;
  logic [31:0] entryData;
  logic [IDSEL_COUNT-1:0] idselBits;

  // Address phase decode.
  wire [3:0] cmd = commandByteEnable_n;
  wire [7:0] busNum = ad[BUS_HI:BUS_LO];
  wire [4:0] devNum = ad[DEV_HI:DEV_LO];
  wire isCfg = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
  wire isWr = cmd == CMD_CFG_WR;
  wire isType0 = ad[1:0] == TYPE0;
  wire isType1 = ad[1:0] == TYPE1;
  wire isIdle = state == S_IDLE;
  wire allOnes = (devNum == DEV_ALL) && (ad[FN_HI:FN_LO] == FN_ALL);
  wire specReg = ad[REG_HI:REG_LO] == SPECIAL_REG;
  wire belowSub = busNum <= subordinateBus;
  wire fromPri = !fromSecondary;
  wire ownHit = fromPri && isCfg && isType0 && primaryConfigSelect;
  wire specDown = fromPri && isWr && isType1 && allOnes && specReg
    && (busNum == secondaryBus);
  wire specUp = fromSecondary && isWr && isType1 && allOnes && specReg
    && (busNum == primaryBus);
  wire convHit = fromPri && isCfg && isType1 && (busNum == secondaryBus);
  wire downHit = fromPri && isCfg && isType1 && (busNum > secondaryBus) && belowSub;
  wire upHit = fromSecondary && isWr && isType1 && allOnes
    && !((busNum >= secondaryBus) && belowSub);
  // Special cycle commands never reach a hit: every hit needs a config command.
  wire kind_t kindNow = ownHit ? KIND_OWN :
    (specDown || specUp) ? KIND_SPEC :
    convHit ? KIND_CONV :
    downHit ? KIND_DOWN :
    upHit ? KIND_UP : KIND_NONE;
  wire delayedNow = (kindNow != KIND_OWN) && (kindNow != KIND_NONE);
  wire attemptMatch = entryBusy && (entryAddr == ad) && (entryCmd == cmd)
    && (entrySide == fromSecondary);
  // A far master abort on a plain delayed request is reflected by not claiming the repeat.
  wire reflectAbort = delayedNow && attemptMatch && entryComplete && entryAborted
    && (kindNow != KIND_SPEC);
  wire claimNow = isIdle && addrPhase && (kindNow != KIND_NONE) && !reflectAbort;

  // Data phase decisions.
  wire heldOwn = heldKind == KIND_OWN;
  wire dataNow = (state == S_CLAIM) && dataPhase;
  wire doneNow = heldMatch && entryComplete;
  wire readyNow = heldOwn || doneNow;
  wire stopNow = readyNow ? moreData : 1'b1;
  wire loadNow = dataNow && !heldOwn && !entryBusy;
  wire clearNow = (isIdle && addrPhase && reflectAbort) || (dataNow && !heldOwn && doneNow);
  wire [31:0] replyData = heldOwn ? cfgReadData : entryData;

  // One-hot select decode: only device numbers below 10h get a line.
  genvar i;
  generate
    for (i = 0; i < IDSEL_COUNT; i = i + 1)
    begin : g_idsel
      assign idselBits[i] = !heldAd[DEV_HI] && (heldAd[DEV_HI-1:DEV_LO] == 4'(i));
    end
  endgenerate

  wire [31:0] convAddr = {idselBits, DEV_ZERO, heldAd[FN_HI:REG_LO], TYPE0};
  wire [31:0] farAddr = (heldKind == KIND_CONV) ? convAddr : heldAd;
  wire [3:0] farCmd = (heldKind == KIND_SPEC) ? CMD_SPECIAL : heldCmd;

  delayed_entry u_entry
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(loadNow),
    .loadAddr(heldAd),
    .loadCmd(heldCmd),
    .loadSide(heldSide),
    .finish(farDone),
    .finishAbort(farMasterAbort),
    .finishData(farReadData),
    .clear(clearNow),
    .busy(entryBusy),
    .complete(entryComplete),
    .aborted(entryAborted),
    .addr(entryAddr),
    .cmd(entryCmd),
    .side(entrySide),
    .data(entryData)
  );

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_IDLE;
      heldKind <= KIND_NONE;
      heldAd <= WORD_ZERO;
      heldCmd <= CMD_SPECIAL;
      heldSide <= 1'b0;
      heldMatch <= 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (claimNow)
          begin
            state <= S_CLAIM;
            heldKind <= kindNow;
            heldAd <= ad;
            heldCmd <= cmd;
            heldSide <= fromSecondary;
            heldMatch <= attemptMatch;
          end
        end
        S_CLAIM:
        begin
          if (dataPhase)
          begin
            state <= S_RESP;
          end
        end
        S_RESP:
        begin
          state <= S_IDLE;
          heldKind <= KIND_NONE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Target-side answer; select stays low from the claim through the response cycle.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      primaryDeviceSelect_n <= SELECT_IDLE_N;
      secondaryDeviceSelect_n <= SELECT_IDLE_N;
      targetReady <= 1'b0;
      targetStop <= 1'b0;
      readData <= WORD_ZERO;
      claimKind <= KIND_NONE;
    end
    else
    begin
      if (claimNow)
      begin
        primaryDeviceSelect_n <= fromSecondary;
        secondaryDeviceSelect_n <= fromPri;
        claimKind <= kindNow;
      end
      else if (state == S_RESP)
      begin
        primaryDeviceSelect_n <= SELECT_IDLE_N;
        secondaryDeviceSelect_n <= SELECT_IDLE_N;
        claimKind <= KIND_NONE;
      end
      targetReady <= dataNow && readyNow;
      targetStop <= dataNow && stopNow;
      if (dataNow && readyNow)
      begin
        readData <= replyData;
      end
    end
  end

  // Own configuration port and far-bus request.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfgIndex <= INDEX_ZERO;
      cfgWrite <= 1'b0;
      cfgWriteData <= WORD_ZERO;
      cfgByteEnable_n <= BE_NONE_N;
      fwdValid <= 1'b0;
      fwdToSecondary <= 1'b0;
      fwdAddr <= WORD_ZERO;
      fwdCommand <= CMD_SPECIAL;
      fwdData <= WORD_ZERO;
      fwdByteEnable_n <= BE_NONE_N;
    end
    else
    begin
      if (claimNow)
      begin
        cfgIndex <= ad[REG_HI:REG_LO];
      end
      cfgWrite <= dataNow && heldOwn && (heldCmd == CMD_CFG_WR);
      if (dataNow && heldOwn)
      begin
        cfgWriteData <= ad;
        cfgByteEnable_n <= commandByteEnable_n;
      end
      fwdValid <= loadNow;
      if (loadNow)
      begin
        fwdToSecondary <= !heldSide;
        fwdAddr <= farAddr;
        fwdCommand <= farCmd;
        fwdData <= ad;
        fwdByteEnable_n <= commandByteEnable_n;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_own_claim: assert property ((addrPhase && isIdle && ownHit) |=> !primaryDeviceSelect_n)
    else $error("own Type 0 access not claimed");
  a_sec_type0: assert property ((addrPhase && isIdle && fromSecondary && isType0)
    |=> (primaryDeviceSelect_n && secondaryDeviceSelect_n))
    else $error("secondary Type 0 access was claimed");
  a_own_single: assert property ((dataNow && heldOwn) |=> (targetReady
    && (targetStop == $past(moreData))) ##1 !targetReady)
    else $error("own access not limited to one DWORD");
  a_full_read: assert property ((dataNow && heldOwn) |=> (readData == $past(cfgReadData)))
    else $error("own read did not return the whole word");
  a_own_immediate: assert property ((dataNow && heldOwn && entryBusy) |=> !fwdValid
    && targetReady)
    else $error("own access waited on the delayed slot");
  a_no_up_type0: assert property ((fwdValid && !fwdToSecondary) |-> (fwdAddr[1:0] == TYPE1))
    else $error("Type 0 cycle sent toward primary");
  a_conv_fields: assert property ((loadNow && heldKind == KIND_CONV)
    |=> (fwdAddr[DEV_HI:DEV_LO] == DEV_ZERO) && (fwdAddr[1:0] == TYPE0)
    && (fwdAddr[FN_HI:REG_LO] == $past(heldAd[FN_HI:REG_LO])))
    else $error("converted address fields wrong");
  a_idsel_decode: assert property ((loadNow && heldKind == KIND_CONV)
    |=> (fwdAddr[31:IDSEL_LO] == ($past(heldAd[DEV_HI]) ? 16'h0000
    : (16'h0001 << $past(heldAd[DEV_HI-1:DEV_LO])))))
    else $error("select line decode wrong");
  a_first_retry: assert property (loadNow |=> (targetStop && !targetReady && fwdValid))
    else $error("new delayed request not retried");
  a_spec_command: assert property ((loadNow && heldKind == KIND_SPEC)
    |=> (fwdCommand == CMD_SPECIAL) && (fwdAddr == $past(heldAd)))
    else $error("special cycle not formed correctly");
  a_ignore_misc: assert property ((addrPhase && isIdle && kindNow == KIND_NONE)
    |=> (primaryDeviceSelect_n && secondaryDeviceSelect_n))
    else $error("unqualified cycle was claimed");

  c_own_access: cover property (dataNow && heldOwn);
  c_conv_issue: cover property (loadNow && heldKind == KIND_CONV);
  c_spec_done: cover property (dataNow && heldKind == KIND_SPEC && doneNow);
  c_reflect_abort: cover property (addrPhase && isIdle && reflectAbort);
endmodule

//--- testbench/far_bus_model.sv
// Far-bus model that ends each forwarded cycle after a set number of cycles.
`timescale 1ns/1ps
module far_bus_model
(
  input wire logic core_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic fwdValid, // Start of a far cycle.
  input wire logic [31:0] fwdAddr, // Far cycle address.
  input wire logic [3:0] fwdCommand, // Far cycle command.
  input wire logic [7:0] lag, // Cycles before the far cycle ends.
  output logic farDone, // End of the far cycle, pulse.
  output logic farMasterAbort, // No target answered.
  output logic [31:0] farReadData // Read data, scrambled while no cycle ends.
);
  import cfg_fwd_pkg::*;
  logic [7:0] count;
  logic busy;
  logic noTarget;
  logic abortSeen;
  logic [31:0] word;
  // Special cycles have no target, and a Type 0 cycle with no select line finds nobody.
  assign noTarget = (fwdCommand == CMD_SPECIAL) ||
    (fwdAddr[1:0] == TYPE0 && fwdAddr[31:16] == 16'h0000);
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      count <= 8'h00;
      abortSeen <= 1'b0;
      word <= 32'h0000_0000;
      farDone <= 1'b0;
      farMasterAbort <= 1'b0;
      farReadData <= 32'h0000_0000;
    end
    else if (fwdValid)
    begin
      busy <= 1'b1;
      count <= lag;
      abortSeen <= noTarget;
      word <= fwdAddr ^ 32'h5A5A_0000;
      farDone <= 1'b0;
      farReadData <= ~farReadData;
    end
    else if (busy && count == 8'h00)
    begin
      busy <= 1'b0;
      farDone <= 1'b1;
      farMasterAbort <= abortSeen;
      farReadData <= word;
    end
    else
    begin
      count <= busy ? count - 8'h01 : count;
      farDone <= 1'b0;
      farReadData <= ~farReadData;
    end
  end
endmodule

//--- testbench/cfg_forward_tb_top.sv
// Self-checking bench for the configuration claim and forwarding block.
`timescale 1ns/1ps
module cfg_forward_tb_top;
  import cfg_fwd_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic addrPhase = 1'b0, fromSecondary = 1'b0, primaryConfigSelect = 1'b0;
  logic dataPhase = 1'b0, moreData = 1'b0;
  logic [31:0] ad = 32'h0000_0000, cfgReadData = 32'h0000_0000;
  logic [3:0] commandByteEnable_n = 4'hF;
  logic [7:0] primaryBus = 8'h00, secondaryBus = 8'h01, subordinateBus = 8'h04, lag = 8'h03;
  logic farDone, farMasterAbort, primaryDeviceSelect_n, secondaryDeviceSelect_n;
  logic targetReady, targetStop, cfgWrite, fwdValid, fwdToSecondary;
  logic [31:0] farReadData, readData, cfgWriteData, fwdAddr, fwdData;
  logic [5:0] cfgIndex;
  logic [3:0] cfgByteEnable_n, fwdCommand, fwdByteEnable_n;
  kind_t claimKind;
  int err_total = 0;
  int total_checks = 0;
  logic sp, ss, rd, st, cw, fv, ft;
  logic [31:0] rdat, cwd, fa, fd;
  logic [5:0] ix;
  logic [3:0] cb, fc, fb;
  kind_t kd;

  always #50 core_clk = ~core_clk;

  cfg_forward dut (.core_clk(core_clk), .nrst(nrst), .addrPhase(addrPhase),
    .fromSecondary(fromSecondary), .ad(ad), .commandByteEnable_n(commandByteEnable_n),
    .primaryConfigSelect(primaryConfigSelect), .dataPhase(dataPhase), .moreData(moreData),
    .primaryBus(primaryBus), .secondaryBus(secondaryBus), .subordinateBus(subordinateBus),
    .cfgReadData(cfgReadData), .farDone(farDone), .farMasterAbort(farMasterAbort),
    .farReadData(farReadData), .claimKind(claimKind),
    .primaryDeviceSelect_n(primaryDeviceSelect_n),
    .secondaryDeviceSelect_n(secondaryDeviceSelect_n), .targetReady(targetReady),
    .targetStop(targetStop), .readData(readData), .cfgIndex(cfgIndex), .cfgWrite(cfgWrite),
    .cfgWriteData(cfgWriteData), .cfgByteEnable_n(cfgByteEnable_n), .fwdValid(fwdValid),
    .fwdToSecondary(fwdToSecondary), .fwdAddr(fwdAddr), .fwdCommand(fwdCommand),
    .fwdData(fwdData), .fwdByteEnable_n(fwdByteEnable_n));

  far_bus_model far (.core_clk(core_clk), .nrst(nrst), .fwdValid(fwdValid),
    .fwdAddr(fwdAddr), .fwdCommand(fwdCommand), .lag(lag), .farDone(farDone),
    .farMasterAbort(farMasterAbort), .farReadData(farReadData));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] t1(input logic [7:0] b, input logic [4:0] d,
    input logic [2:0] f, input logic [5:0] r);
    return {8'h00, b, d, f, r, TYPE1};
  endfunction

  // One transaction: address phase, one data phase, then the response is captured.
  task automatic txn(input logic [31:0] a, input logic [3:0] c, input logic sec, sel, more,
    input logic [31:0] w);
    @(posedge core_clk);
    addrPhase <= 1'b1;
    ad <= a;
    commandByteEnable_n <= c;
    fromSecondary <= sec;
    primaryConfigSelect <= sel;
    cfgReadData <= 32'hC0DE_0000 ^ a;
    @(posedge core_clk);
    addrPhase <= 1'b0;
    ad <= ~a;
    #1;
    {sp, ss, ix} = {primaryDeviceSelect_n, secondaryDeviceSelect_n, cfgIndex};
    kd = claimKind;
    @(posedge core_clk);
    dataPhase <= 1'b1;
    ad <= w;
    commandByteEnable_n <= 4'h3;
    moreData <= more;
    @(posedge core_clk);
    dataPhase <= 1'b0;
    moreData <= 1'b0;
    #1;
    {rd, st, cw, fv, ft} = {targetReady, targetStop, cfgWrite, fwdValid, fwdToSecondary};
    {rdat, cwd, cb, fa, fc, fd} = {readData, cfgWriteData, cfgByteEnable_n, fwdAddr,
      fwdCommand, fwdData};
    fb = fwdByteEnable_n;
  endtask

  task automatic resp(input logic p, s, r, t);
    chk("primary select", 32'(p), 32'(sp));
    chk("secondary select", 32'(s), 32'(ss));
    chk("target ready", 32'(r), 32'(rd));
    chk("target stop", 32'(t), 32'(st));
  endtask

  task automatic none(input logic [31:0] a, input logic [3:0] c, input logic sec, sel);
    txn(a, c, sec, sel, 1'b0, 32'h0000_0000);
    resp(1'b1, 1'b1, 1'b0, 1'b0);
    chk("far start", 32'h0, 32'(fv));
  endtask

  task automatic wait_far();
    int n;
    n = 0;
    while (farDone !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("far cycle end", 32'h1, 32'(farDone));
  endtask

  // First attempt is retried and forwarded; the repeat completes or is left unclaimed.
  task automatic delayed(input logic [31:0] a, ea, input logic [3:0] c, ec,
    input logic sec, lost, more);
    logic [31:0] w;
    w = 32'h600D_0000 ^ a;
    txn(a, c, sec, 1'b0, 1'b0, w);
    resp(sec, !sec, 1'b0, 1'b1);
    chk("far start", 32'h1, 32'(fv));
    chk("far side", 32'(!sec), 32'(ft));
    chk("far address", ea, fa);
    chk("far command", 32'(ec), 32'(fc));
    chk("far enables", 32'h3, 32'(fb));
    if (c == CMD_CFG_WR)
      chk("far data", w, fd);
    wait_far();
    txn(a, c, sec, 1'b0, more, w);
    if (lost)
      resp(1'b1, 1'b1, 1'b0, 1'b0);
    else
      resp(sec, !sec, 1'b1, more);
    if (!lost && c == CMD_CFG_RD)
      chk("far read data", ea ^ 32'h5A5A_0000, rdat);
  endtask

  task automatic own_access();
    txn(32'h0000_0008, CMD_CFG_RD, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    resp(1'b0, 1'b1, 1'b1, 1'b1);
    chk("kind", 32'(KIND_OWN), 32'(kd));
    chk("index", 32'h2, 32'(ix));
    chk("read word", 32'hC0DE_0008, rdat);
    txn(32'h0000_0010, CMD_CFG_WR, 1'b0, 1'b1, 1'b0, 32'h1234_5678);
    resp(1'b0, 1'b1, 1'b1, 1'b0);
    chk("config write", 32'h1, 32'(cw));
    chk("write word", 32'h1234_5678, cwd);
    chk("write enables", 32'h3, 32'(cb));
  endtask

  task automatic refusals();
    none(32'h0000_0008, CMD_CFG_RD, 1'b0, 1'b0);
    none(32'h0000_000A, CMD_CFG_RD, 1'b0, 1'b1);
    none(32'h0000_0008, CMD_CFG_WR, 1'b1, 1'b1);
    none(32'h0000_0008, CMD_SPECIAL, 1'b0, 1'b1);
    none(t1(8'h05, 5'h02, 3'h0, 6'h01), CMD_CFG_RD, 1'b0, 1'b0);
    none(t1(8'h09, 5'h1F, 3'h7, 6'h04), CMD_CFG_RD, 1'b1, 1'b0);
    none(t1(8'h02, 5'h1F, 3'h7, 6'h04), CMD_CFG_WR, 1'b1, 1'b0);
  endtask

  task automatic conv();
    logic [4:0] devs [5] = '{5'h00, 5'h05, 5'h0F, 5'h10, 5'h1E};
    logic [15:0] sel;
    logic [3:0] c;
    foreach (devs[i])
    begin
      sel = devs[i] < 5'h10 ? 16'h0001 << devs[i] : 16'h0000;
      c = i[0] ? CMD_CFG_WR : CMD_CFG_RD;
      delayed(t1(8'h01, devs[i], 3'h5, 6'h2A), {sel, 5'h00, 3'h5, 6'h2A, TYPE0}, c, c,
        1'b0, devs[i] > 5'h0F, 1'b0);
    end
  endtask

  task automatic forward();
    delayed(t1(8'h02, 5'h03, 3'h1, 6'h05), t1(8'h02, 5'h03, 3'h1, 6'h05), CMD_CFG_RD,
      CMD_CFG_RD, 1'b0, 1'b0, 1'b0);
    delayed(t1(8'h04, 5'h03, 3'h1, 6'h05), t1(8'h04, 5'h03, 3'h1, 6'h05), CMD_CFG_WR,
      CMD_CFG_WR, 1'b0, 1'b0, 1'b1);
    delayed(t1(8'h09, 5'h1F, 3'h7, 6'h04), t1(8'h09, 5'h1F, 3'h7, 6'h04), CMD_CFG_WR,
      CMD_CFG_WR, 1'b1, 1'b0, 1'b1);
    delayed(t1(8'h01, 5'h1F, 3'h7, 6'h00), t1(8'h01, 5'h1F, 3'h7, 6'h00), CMD_CFG_WR,
      CMD_SPECIAL, 1'b0, 1'b0, 1'b1);
    delayed(t1(8'h00, 5'h1F, 3'h7, 6'h00), t1(8'h00, 5'h1F, 3'h7, 6'h00), CMD_CFG_WR,
      CMD_SPECIAL, 1'b1, 1'b0, 1'b1);
  endtask

  // A slow far bus keeps the slot busy while other requests arrive.
  task automatic busy_slot();
    @(posedge core_clk);
    lag <= 8'h3C;
    txn(t1(8'h01, 5'h02, 3'h0, 6'h08), CMD_CFG_RD, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    resp(1'b0, 1'b1, 1'b0, 1'b1);
    txn(t1(8'h03, 5'h02, 3'h0, 6'h08), CMD_CFG_RD, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    resp(1'b0, 1'b1, 1'b0, 1'b1);
    chk("far start", 32'h0, 32'(fv));
    txn(32'h0000_0004, CMD_CFG_RD, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
    resp(1'b0, 1'b1, 1'b1, 1'b0);
    chk("read word", 32'hC0DE_0004, rdat);
    wait_far();
    txn(t1(8'h01, 5'h02, 3'h0, 6'h08), CMD_CFG_RD, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    resp(1'b0, 1'b1, 1'b1, 1'b0);
    chk("far read data", 32'h5A5E_0020, rdat);
    lag <= 8'h03;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    own_access();
    refusals();
    conv();
    forward();
    busy_slot();
    end_sim();
  end

  // The whole run needs well under a tenth of this span.
  initial
  begin
    #2000000;
    err_total++;
    end_sim();
  end
endmodule
